//--- sms_pkg.sv
// Purpose: constants and types of the standby mode sequencer
// Assumes: 32-bit APB register access, byte addresses
// Notes:   offsets below are word aligned

package sms_pkg;

    // ************************************************
    // register map
    // ************************************************
    localparam logic [7:0] SMS_OFS_STBY_CTRL = 8'h00;
    localparam logic [7:0] SMS_OFS_WDT_CSR   = 8'h04;
    localparam logic [7:0] SMS_OFS_WDT_RST   = 8'h08;
    localparam logic [7:0] SMS_OFS_INT_CTRL  = 8'h0c;
    localparam logic [7:0] SMS_OFS_STATUS    = 8'h10;
    localparam logic [7:0] SMS_OFS_WDT_CNT   = 8'h14;

    // ************************************************
    // standby control register fields
    // ************************************************
    localparam int         SMS_BIT_SBY     = 7;
    localparam int         SMS_BIT_FLOAT   = 6;
    localparam logic [7:0] SMS_STBY_RESET  = 8'h1f;
    localparam logic [5:0] SMS_STBY_FIXED  = 6'h1f;

    // ************************************************
    // watchdog control/status fields
    // ************************************************
    localparam int         SMS_BIT_OVF     = 7;
    localparam int         SMS_BIT_INTV    = 6;
    localparam int         SMS_BIT_RUN     = 5;
    localparam int         SMS_CKS_HI      = 2;
    localparam logic [7:0] SMS_CSR_RESET   = 8'h18;
    localparam logic [7:0] SMS_RST_RESET   = 8'h1f;
    localparam logic [7:0] SMS_CNT_MAX     = 8'hff;

    // ************************************************
    // interrupt control fields
    // ************************************************
    localparam int         SMS_BIT_NMI_EDGE_POLARITY    = 8;

    // ************************************************
    // sequencer states
    // ************************************************
    typedef enum logic [1:0] {
        SMS_RUN   = 2'b00,
        SMS_STBY  = 2'b01,
        SMS_WARM  = 2'b10
    } sms_state_t;

endpackage

//--- sms_standby_seq.sv
// Purpose: standby mode power-down sequencer with APB register access
// Assumes: single 125 MHz clock, pins synchronised here
// Notes:   the watchdog prescaler stands in for the stabilisation timer
//
// Summary of operation
// - halt executed with standby select set enters standby.
// - standby gates system clock, cpu and peripheral clocks.
// - cpu registers and ram keep contents; their clocks only stop.
// - port pins held or floated according to port float select.
// - entry clears transfer-controller registers except data holding.
// - entry clears multi-timer registers, keeps output-disable unit.
// - entry clears watchdog bits 7..5 and reset status; keeps cks, count.
// - entry clears serial, analog converter and compare timer registers.
// - interrupt, break, cache, bus, pin function and ports keep state.
// - standby control register survives standby.
// - only nmi edge, power-on or manual reset end standby.
// - nmi edge of chosen polarity restarts oscillation.
// - after restart only watchdog clocked until it overflows.
// - overflow clocks whole chip, leaves standby, starts nmi handling.
// - power-on clear low ends standby through power-on reset.
// - polarity bit 0 selects falling edge, 1 rising edge.
// - standby select at bit 7; register resets to 0x1f.
// - port float select at bit 6; 1 floats ports in standby.
// - select bits cannot be set while watchdog run enable is 1.
// - manual clear low with power-on clear high ends standby.

`timescale 1ns/1ns

module sms_standby_seq #(
    parameter int PRESC_W = 12
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        clkEn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // cpu side
    input  wire logic        haltExec,
    // pins
    input  wire logic        nmiPin,
    input  wire logic        power_on_clear_n,
    input  wire logic        manual_clear_n,
    // power control outputs
    output logic             cpuHalt,
    output logic             sysClkEn,
    output logic             wdtClkEn,
    output logic             portHold,
    output logic             portFloat,
    output logic             periphInit,
    output logic             nmiException,
    output logic             powerOnReset,
    output logic             manualReset
);
    import sms_pkg::*;

    // the tap offset is PRESC_W less the count width, so it must not go
    // negative; the five-bit tap index caps the top end
    if (PRESC_W < 8 || PRESC_W > 24) begin : gPrescRange
        $error("PRESC_W out of range");
    end

    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic       nmiS;
    logic       nmiPrev;
    logic       porS;
    logic       mrsS;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            syncA <= 3'h7;
            syncB <= 3'h7;
        end else if (clkEn) begin
            syncA <= {nmiPin, power_on_clear_n, manual_clear_n};
            syncB <= syncA;
        end
    end

    assign nmiS = syncB[2];
    assign porS = syncB[1];
    assign mrsS = syncB[0];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            nmiPrev <= 1'b1;
        end else if (clkEn) begin
            nmiPrev <= nmiS;
        end
    end

    // ************************************************
    // registers
    // ************************************************
    logic       sbySel;
    logic       floatSel;
    logic [7:0] wdtCsr;
    logic [7:0] wdtRst;
    logic       edgePol;
    logic [7:0] wdtCnt;
    logic [PRESC_W-1:0] presc;
    sms_state_t state;

    logic wrAcc;
    logic nmiEdge;
    logic porHit;
    logic mrsHit;
    logic entry;
    logic wdtTick;
    logic overflow;

    // writes land only at the edge where the master sees pready high
    assign wrAcc = psel && penable && pwrite && pready;
    // polarity 0 falling, 1 rising
    assign nmiEdge = edgePol ? (nmiS && !nmiPrev)
                             : (!nmiS && nmiPrev);
    assign porHit = !porS;
    assign mrsHit = porS && !mrsS;
    assign entry = (state == SMS_RUN) && haltExec && sbySel;

    // prescaler tap picked by clock select; wider tap = longer settle
    logic [4:0] tapIdx;
    assign tapIdx = 5'(wdtCsr[SMS_CKS_HI:0])
                  + 5'(PRESC_W - $bits(wdtCnt));

    // mask covers every prescaler stage up to and including the tap
    logic [PRESC_W-1:0] tapMask;
    for (genvar i = 0; i < PRESC_W; i++) begin : gTapMask
        assign tapMask[i] = (5'(i) <= tapIdx);
    end
    // one tick per wrap of the masked stages; cks 0 ticks every 2nd cycle when PRESC_W is 8
    assign wdtTick = (state == SMS_WARM)
                   && ((presc & tapMask) == tapMask);
    assign overflow = wdtTick && (wdtCnt == SMS_CNT_MAX);

    // standby control: writes honoured in run state only, select bits gated by run enable
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sbySel   <= SMS_STBY_RESET[SMS_BIT_SBY];
            floatSel <= SMS_STBY_RESET[SMS_BIT_FLOAT];
        end else if (clkEn) begin
            if (porHit) begin
                sbySel   <= SMS_STBY_RESET[SMS_BIT_SBY];
                floatSel <= SMS_STBY_RESET[SMS_BIT_FLOAT];
            end else if (wrAcc && paddr == SMS_OFS_STBY_CTRL
                         && state == SMS_RUN) begin
                // untouched by standby entry or exit
                sbySel   <= pwdata[SMS_BIT_SBY]
                          && !wdtCsr[SMS_BIT_RUN];
                floatSel <= pwdata[SMS_BIT_FLOAT]
                          && !wdtCsr[SMS_BIT_RUN];
            end
        end
    end

    // interrupt control polarity, retained across standby
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            edgePol <= 1'b0;
        end else if (clkEn) begin
            if (porHit) begin
                edgePol <= 1'b0;
            end else if (wrAcc && paddr == SMS_OFS_INT_CTRL
                         && state == SMS_RUN) begin
                edgePol <= pwdata[SMS_BIT_NMI_EDGE_POLARITY];
            end
        end
    end

    // watchdog control/status and reset status
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wdtCsr <= SMS_CSR_RESET;
            wdtRst <= SMS_RST_RESET;
        end else if (clkEn) begin
            if (porHit) begin
                wdtCsr <= SMS_CSR_RESET;
                wdtRst <= SMS_RST_RESET;
            end else if (entry) begin
                wdtCsr[SMS_BIT_OVF:SMS_BIT_RUN] <=
                    SMS_CSR_RESET[SMS_BIT_OVF:SMS_BIT_RUN];
                wdtRst <= SMS_RST_RESET;
            end else if (overflow) begin
                wdtCsr[SMS_BIT_OVF] <= 1'b1;
            end else if (wrAcc && state == SMS_RUN) begin
                if (paddr == SMS_OFS_WDT_CSR) begin
                    wdtCsr <= pwdata[7:0];
                end
                if (paddr == SMS_OFS_WDT_RST) begin
                    wdtRst <= pwdata[7:0];
                end
            end
        end
    end

    // warm-up prescaler and counter; counter kept over entry
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            presc  <= '0;
            wdtCnt <= '0;
        end else if (clkEn) begin
            if (porHit) begin
                presc  <= '0;
                wdtCnt <= '0;
            end else if (state == SMS_WARM) begin
                presc <= presc + 1'b1;
                if (wdtTick) begin
                    wdtCnt <= wdtCnt + 8'h01;
                end
            end else begin
                presc <= '0;
                if (wrAcc && paddr == SMS_OFS_WDT_CNT
                    && state == SMS_RUN) begin
                    wdtCnt <= pwdata[7:0];
                end
            end
        end
    end

    // ************************************************
    // sequencer
    // ************************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= SMS_RUN;
        end else if (clkEn) begin
            // either reset overrides any state, standby included
            if (porHit || mrsHit) begin
                state <= SMS_RUN;
            end else begin
                unique case (state)
                    SMS_RUN: begin
                        if (entry) begin
                            state <= SMS_STBY;
                        end
                    end
                    SMS_STBY: begin
                        if (nmiEdge) begin
                            state <= SMS_WARM;
                        end
                    end
                    SMS_WARM: begin
                        if (overflow) begin
                            state <= SMS_RUN;
                        end
                    end
                    default: begin
                        state <= SMS_RUN;
                    end
                endcase
            end
        end
    end

    // ************************************************
    // power control outputs
    // ************************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cpuHalt      <= 1'b0;
            sysClkEn     <= 1'b1;
            wdtClkEn     <= 1'b1;
            portHold     <= 1'b0;
            portFloat    <= 1'b0;
            periphInit   <= 1'b0;
            nmiException <= 1'b0;
            powerOnReset <= 1'b0;
            manualReset  <= 1'b0;
        end else if (clkEn) begin
            powerOnReset <= porHit;
            manualReset  <= mrsHit;
            // one-cycle pulse: peripherals clear on entry only
            periphInit   <= entry && !porHit && !mrsHit;
            nmiException <= overflow && !porHit && !mrsHit;
            if (porHit || mrsHit || overflow) begin
                cpuHalt   <= 1'b0;
                sysClkEn  <= 1'b1;
                wdtClkEn  <= 1'b1;
                portHold  <= 1'b0;
                portFloat <= 1'b0;
            end else if (entry) begin
                cpuHalt   <= 1'b1;
                sysClkEn  <= 1'b0;
                wdtClkEn  <= 1'b0;
                portHold  <= !floatSel;
                portFloat <= floatSel;
            // warm-up: only the watchdog runs until the count overflows
            end else if (state == SMS_STBY && nmiEdge) begin
                wdtClkEn  <= 1'b1;
            end
        end
    end

    // ************************************************
    // apb read side
    // ************************************************
    logic [31:0] next_prdata;
    logic        next_err;

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_err    = 1'b0;
        unique case (paddr)
            SMS_OFS_STBY_CTRL: next_prdata[7:0] =
                {sbySel, floatSel, SMS_STBY_FIXED};
            SMS_OFS_WDT_CSR:   next_prdata[7:0] = wdtCsr;
            SMS_OFS_WDT_RST:   next_prdata[7:0] = wdtRst;
            SMS_OFS_INT_CTRL:  next_prdata[SMS_BIT_NMI_EDGE_POLARITY] = edgePol;
            SMS_OFS_STATUS:    next_prdata[1:0] = state;
            SMS_OFS_WDT_CNT:   next_prdata[7:0] = wdtCnt;
            default:           next_err = 1'b1;
        endcase
    end

    // one wait state: ready in the second access cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && next_err;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

endmodule

//--- sms_standby_seq_monitor.sv
// Purpose: port-level checks of the standby sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   reset pin checks allow for the input synchroniser lag
`timescale 1ns/1ns
module sms_standby_seq_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // cpu and pins
    input wire logic haltExec,
    input wire logic power_on_clear_n,
    input wire logic manual_clear_n,
    // power control
    input wire logic cpuHalt,
    input wire logic sysClkEn,
    input wire logic wdtClkEn,
    input wire logic portHold,
    input wire logic portFloat,
    input wire logic periphInit,
    input wire logic nmiException,
    input wire logic powerOnReset,
    input wire logic manualReset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ************************************************
    // entry and stay
    // ************************************************
    chk_entry_cause: assert property (
        $rose(cpuHalt) |-> $past(haltExec)) else $error("entry without halt");
    chk_clocks_gated: assert property (
        $rose(cpuHalt) |-> !sysClkEn && !wdtClkEn)
        else $error("clocks run at entry");
    chk_init_pulse: assert property (
        periphInit |-> $rose(cpuHalt)) else $error("init pulse off entry");
    chk_init_entry: assert property (
        $rose(cpuHalt) |-> periphInit) else $error("entry without init pulse");
    chk_port_mode: assert property (
        portFloat |-> cpuHalt && !portHold) else $error("float outside stay");
    chk_halt_gates: assert property (
        cpuHalt |-> !sysClkEn) else $error("system clock while halted");
    // ************************************************
    // exit
    // ************************************************
    chk_warm_only: assert property (
        $rose(wdtClkEn) && cpuHalt |-> !sysClkEn && !nmiException)
        else $error("warm-up clocks more than watchdog");
    chk_wake_exit: assert property (
        nmiException |-> $fell(cpuHalt) && sysClkEn && wdtClkEn)
        else $error("wake pulse without full clocks");
    chk_exit_cause: assert property (
        $fell(cpuHalt) |-> nmiException || powerOnReset || manualReset
            || $past(powerOnReset) || $past(manualReset))
        else $error("standby left without cause");
    chk_manual_clear: assert property (
        (!manual_clear_n && power_on_clear_n) [*5] |-> manualReset)
        else $error("manual reset missing");
    chk_poweron_clear: assert property (
        (!power_on_clear_n) [*6] |-> powerOnReset && !cpuHalt)
        else $error("power-on reset missing");
endmodule
bind sms_standby_seq sms_standby_seq_monitor sms_standby_seq_monitor_inst (
    .clock(clock), .arst_n(arst_n), .haltExec(haltExec),
    .power_on_clear_n(power_on_clear_n), .manual_clear_n(manual_clear_n),
    .cpuHalt(cpuHalt), .sysClkEn(sysClkEn), .wdtClkEn(wdtClkEn),
    .portHold(portHold), .portFloat(portFloat), .periphInit(periphInit),
    .nmiException(nmiException), .powerOnReset(powerOnReset),
    .manualReset(manualReset));

//--- sms_partner_model.sv
// Purpose: cpu halt strobe and external nmi and reset pins
// Assumes: driven just after rising edges
// Notes:   pins idle high, nmi level set by the caller
`timescale 1ns/1ns
module sms_partner_model (
    // clock
    input wire logic clock,
    // cpu and pins
    output logic     haltExec,
    output logic     nmiPin,
    output logic     power_on_clear_n,
    output logic     manual_clear_n
);
    initial begin
        haltExec = 1'b0;
        nmiPin = 1'b1;
        power_on_clear_n = 1'b1;
        manual_clear_n = 1'b1;
    end
    task automatic halt();
        @(posedge clock) haltExec <= 1'b1;
        @(posedge clock) haltExec <= 1'b0;
    endtask
    // nmi level kept opposite the wake edge before entry
    task automatic pins(input logic nmi, input logic por, input logic man);
        @(posedge clock);
        nmiPin <= nmi;
        power_on_clear_n <= por;
        manual_clear_n <= man;
    endtask
endmodule

//--- sms_standby_seq_bench.sv
// Purpose: apb driven checks of the standby sequencer
// Assumes: prescaler shortened to 8 bits, cks 0 then 1
// Notes:   count preloaded near overflow to keep warm-up short
`timescale 1ns/1ns
module sms_standby_seq_bench;
    import sms_pkg::*;
    logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, cpuHalt, sysClkEn, wdtClkEn;
    logic portHold, portFloat, periphInit, nmiException, powerOnReset;
    logic manualReset, haltExec, nmiPin, power_on_clear_n, manual_clear_n;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic clkEn = 1'b1, err;
    int fail_count = 0, num_checks = 0, n;
    always #4 clock = ~clock;
    sms_partner_model sms_partner_model_inst (.clock(clock),
        .haltExec(haltExec), .nmiPin(nmiPin),
        .power_on_clear_n(power_on_clear_n), .manual_clear_n(manual_clear_n));
    sms_standby_seq #(.PRESC_W(8)) sms_standby_seq_inst (.clock(clock),
        .arst_n(arst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .haltExec(haltExec),
        .nmiPin(nmiPin), .power_on_clear_n(power_on_clear_n),
        .manual_clear_n(manual_clear_n), .cpuHalt(cpuHalt),
        .sysClkEn(sysClkEn), .wdtClkEn(wdtClkEn), .portHold(portHold),
        .portFloat(portFloat), .periphInit(periphInit),
        .nmiException(nmiException), .powerOnReset(powerOnReset),
        .manualReset(manualReset));
    // ************************************************
    // bench tasks
    // ************************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clock);
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        rdchk(SMS_OFS_STBY_CTRL, 32'h1f);
        rdchk(SMS_OFS_WDT_CSR, 32'h18);
        rdchk(SMS_OFS_WDT_RST, 32'h1f);
        apb(1'b0, 8'h40, 32'h0);
        check(err, 1'b1);
        apb(1'b1, SMS_OFS_WDT_CSR, 32'h20);
        apb(1'b1, SMS_OFS_STBY_CTRL, 32'hdf);
        rdchk(SMS_OFS_STBY_CTRL, 32'h1f);
        apb(1'b1, SMS_OFS_WDT_CSR, 32'h00);
        apb(1'b1, SMS_OFS_STBY_CTRL, 32'h1f);
        sms_partner_model_inst.halt();
        idle(3);
        check(cpuHalt, 1'b0);
        rdchk(SMS_OFS_STATUS, 32'h0);
        for (int p = 0; p < 2; p++) begin
            sms_partner_model_inst.pins(!p, 1'b1, 1'b1);
            apb(1'b1, SMS_OFS_INT_CTRL, 32'(p) << SMS_BIT_NMI_EDGE_POLARITY);
            apb(1'b1, SMS_OFS_WDT_CSR, 32'h40 | 32'(p));
            apb(1'b1, SMS_OFS_WDT_CNT, 32'hf0);
            apb(1'b1, SMS_OFS_STBY_CTRL, 32'h9f | (32'(p) << 6));
            sms_partner_model_inst.halt();
            @(posedge clock);
            check(periphInit, 1'b1);
            idle(1);
            check({cpuHalt, sysClkEn, wdtClkEn}, 3'b100);
            check({portHold, portFloat}, p ? 2'b01 : 2'b10);
            apb(1'b1, SMS_OFS_STBY_CTRL, 32'h1f);
            rdchk(SMS_OFS_STBY_CTRL, 32'h9f | (32'(p) << 6));
            rdchk(SMS_OFS_WDT_CSR, 32'(p));
            rdchk(SMS_OFS_WDT_CNT, 32'hf0);
            rdchk(SMS_OFS_INT_CTRL, 32'(p) << SMS_BIT_NMI_EDGE_POLARITY);
            idle(20);
            rdchk(SMS_OFS_STATUS, 32'h1);
            sms_partner_model_inst.pins(p, 1'b1, 1'b1);
            n = 0;
            while (nmiException !== 1'b1 && n < 300) begin
                @(posedge clock);
                n++;
            end
            check(n < 300, 1'b1);
            idle(1);
            check({cpuHalt, sysClkEn}, 2'b01);
            rdchk(SMS_OFS_STATUS, 32'h0);
            rdchk(SMS_OFS_WDT_CSR, 32'h80 | 32'(p));
        end
        // frozen clock enable: a halt strobe must leave no trace
        @(posedge clock) clkEn <= 1'b0;
        sms_partner_model_inst.halt();
        idle(2);
        check({cpuHalt, periphInit}, 2'b00);
        @(posedge clock) clkEn <= 1'b1;
        rdchk(SMS_OFS_STATUS, 32'h0);
        sms_partner_model_inst.halt();
        idle(2);
        sms_partner_model_inst.pins(1'b1, 1'b1, 1'b0);
        idle(6);
        check({manualReset, cpuHalt}, 2'b10);
        sms_partner_model_inst.pins(1'b1, 1'b1, 1'b1);
        idle(6);
        rdchk(SMS_OFS_STBY_CTRL, 32'hdf);
        sms_partner_model_inst.halt();
        idle(2);
        sms_partner_model_inst.pins(1'b1, 1'b0, 1'b1);
        idle(8);
        check({powerOnReset, cpuHalt}, 2'b10);
        sms_partner_model_inst.pins(1'b1, 1'b1, 1'b1);
        idle(6);
        rdchk(SMS_OFS_STBY_CTRL, 32'h1f);
        rdchk(SMS_OFS_STATUS, 32'h0);
        summarize();
    end
endmodule
